// ### phy_host_link_selector.sv
// Purpose: chipset end of the PHY in-band link, path selection
// Assumes: serial link framing done by an outer serdes, same clock
// Notes:   platform reset level picks serial link or sideband
`timescale 1ns/100ps
module phy_host_link_selector
  import phy_link_pkg::*;
(
  input  wire logic      i_clk,
  input  wire logic      i_rst_b,
  input  wire logic      i_sys_active,
  input  wire sb_speed_t i_sb_speed,
  input  wire beat_t     i_tx,
  output logic           o_tx_ready,
  output logic           o_tx_abort,
  input  wire beat_t     i_msg,
  output logic           o_msg_ready,
  output logic           o_msg_acked,
  output beat_t          o_rx,
  output logic           o_rx_abort,
  input  wire logic      i_rx_poll,
  input  wire logic      i_rx_poll_last,
  output beat_t          o_serial_tx,
  input  wire logic      i_serial_ready,
  input  wire beat_t     i_serial_rx,
  input  wire logic      i_serial_msg_ack,
  output logic           o_serial_enable,
  output logic           o_platform_reset_n,
  input  wire logic      i_refclk_req_n,
  output logic           o_refclk_en,
  input  wire logic      i_sideband_data_pin,
  output logic           o_sideband_data_pin,
  output logic           o_sideband_data_pin_oe,
  input  wire logic      i_sideband_clock_pin,
  output logic           o_sideband_clock_pin,
  output logic           o_sideband_clock_pin_oe
);
  tx_state_t  state_ff, nxt_state;
  path_t      path_ff, nxt_path;
  logic       prst_ff, nxt_prst;
  beat_t      ser_ff, nxt_ser, rx_ff, nxt_rx;
  logic       rx_in_frame_ff, nxt_rx_in_frame;
  logic       tx_abort_ff, nxt_tx_abort, rx_abort_ff, nxt_rx_abort;
  logic       pend_ff, nxt_pend, sent_ff, nxt_sent;
  logic [7:0] msg_ff, nxt_msg;
  logic       acked_ff, nxt_acked, poll_last_ff, nxt_poll_last;
  logic [1:0] req_sync_ff;
  logic       sw_evt, ser_free, sb_start, sb_read;
  logic [7:0] sb_byte;
  logic       sb_busy, sb_done, sb_ack;
  logic [7:0] sb_rd_byte;

  // ****************************************************************
  // sideband engine
  // ****************************************************************
  sideband_shifter u_sb (
    .i_clk     (i_clk),
    .i_rst_b   (i_rst_b),
    .i_start   (sb_start),
    .i_abort   (sw_evt),
    .i_read    (sb_read),
    .i_byte    (sb_byte),
    .i_half    (sb_half_cycles(i_sb_speed)),
    .i_sda_in  (i_sideband_data_pin),
    .i_scl_in  (i_sideband_clock_pin),
    .o_sda_out (o_sideband_data_pin),
    .o_sda_oe  (o_sideband_data_pin_oe),
    .o_scl_out (o_sideband_clock_pin),
    .o_scl_oe  (o_sideband_clock_pin_oe),
    .o_busy    (sb_busy),
    .o_done    (sb_done),
    .o_ack     (sb_ack),
    .o_rd_byte (sb_rd_byte)
  );

  // ****************************************************************
  // clock request synchroniser
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      req_sync_ff <= 2'h3;
    end else begin
      req_sync_ff <= {req_sync_ff[0], i_refclk_req_n};
    end
  end

  // a switch is any change of the power-good level we drive
  assign sw_evt   = (i_sys_active != prst_ff);
  assign ser_free = ~ser_ff.valid | i_serial_ready;

  // ****************************************************************
  // path, transmit and message sequencing
  // ****************************************************************
  always_comb begin
    nxt_state     = state_ff;
    nxt_prst      = i_sys_active;
    nxt_path      = i_sys_active ? PATH_SERIAL : PATH_SIDEBAND;
    nxt_ser       = ser_ff;
    nxt_tx_abort  = 1'b0;
    nxt_pend      = pend_ff;
    nxt_sent      = sent_ff;
    nxt_msg       = msg_ff;
    nxt_acked     = 1'b0;
    nxt_poll_last = poll_last_ff;
    o_tx_ready    = 1'b0;
    sb_start      = 1'b0;
    sb_read       = 1'b0;
    sb_byte       = msg_ff;
    if (ser_ff.valid && i_serial_ready) begin
      nxt_ser.valid = 1'b0;
    end
    // new message latched only while none is outstanding
    if (!pend_ff && i_msg.valid) begin
      nxt_pend = 1'b1;
      nxt_sent = 1'b0;
      nxt_msg  = i_msg.data;
    end
    if (pend_ff && sent_ff && path_ff == PATH_SERIAL
        && i_serial_msg_ack) begin
      nxt_pend  = 1'b0;
      nxt_acked = 1'b1;
    end
    unique case (state_ff)
      TX_IDLE: begin
        if (pend_ff && !sent_ff && path_ff == PATH_SERIAL) begin
          if (ser_free) begin
            nxt_ser  = '{data: msg_ff, last: 1'b1, msg: 1'b1,
                         valid: 1'b1};
            nxt_sent = 1'b1;
          end
        end else if (pend_ff && !sent_ff && !sb_busy) begin
          sb_start  = 1'b1;
          nxt_sent  = 1'b1;
          nxt_state = TX_MSG_SB;
        end else if (i_tx.valid && path_ff == PATH_SERIAL) begin
          nxt_state = TX_FRAME;
        end else if (i_tx.valid && !sb_busy) begin
          nxt_state = TX_FRAME;
        end else if (i_rx_poll && path_ff == PATH_SIDEBAND
                     && !sb_busy) begin
          sb_start      = 1'b1;
          sb_read       = 1'b1;
          nxt_poll_last = i_rx_poll_last;
          nxt_state     = TX_RD;
        end
      end
      TX_FRAME: begin
        // one path at a time; the other sees nothing
        if (path_ff == PATH_SERIAL) begin
          o_tx_ready = ser_free;
          if (ser_free && i_tx.valid) begin
            nxt_ser = '{data: i_tx.data, last: i_tx.last, msg: 1'b0,
                        valid: 1'b1};
          end
        end else begin
          o_tx_ready = ~sb_busy;
          sb_byte    = i_tx.data;
          sb_start   = ~sb_busy & i_tx.valid;
        end
        if (o_tx_ready && i_tx.valid && i_tx.last) begin
          nxt_state = TX_IDLE;
        end
      end
      TX_DROP: begin
        // swallow the rest of a frame cut by a switch
        o_tx_ready = 1'b1;
        if (i_tx.valid && i_tx.last) begin
          nxt_state = TX_IDLE;
        end
      end
      TX_MSG_SB: begin
        if (sb_done) begin
          nxt_pend  = ~sb_ack;
          nxt_sent  = ~sb_ack ? 1'b0 : sent_ff;
          nxt_acked = sb_ack;
          nxt_state = TX_IDLE;
        end
      end
      TX_RD: begin
        if (sb_done) begin
          nxt_state = TX_IDLE;
        end
      end
      default: nxt_state = TX_IDLE;
    endcase
    // switch: cut frames, requeue unacked message on new path
    if (sw_evt) begin
      nxt_ser.valid = 1'b0;
      if (pend_ff) begin
        nxt_sent = 1'b0;
      end
      if (state_ff == TX_FRAME) begin
        nxt_tx_abort = 1'b1;
        nxt_state    = (o_tx_ready && i_tx.valid && i_tx.last)
                       ? TX_IDLE : TX_DROP;
      end else if (state_ff != TX_DROP) begin
        nxt_state = TX_IDLE;
      end
    end
  end

  // ****************************************************************
  // receive path
  // ****************************************************************
  // bytes from the inactive path are never forwarded
  always_comb begin
    nxt_rx          = '0;
    nxt_rx_in_frame = rx_in_frame_ff;
    nxt_rx_abort    = 1'b0;
    if (path_ff == PATH_SERIAL && i_serial_rx.valid) begin
      nxt_rx          = i_serial_rx;
      nxt_rx_in_frame = ~i_serial_rx.last;
    end else if (state_ff == TX_RD && sb_done && !sw_evt) begin
      nxt_rx          = '{data: sb_rd_byte, last: poll_last_ff,
                          msg: 1'b0, valid: 1'b1};
      nxt_rx_in_frame = ~poll_last_ff;
    end
    if (sw_evt) begin
      nxt_rx          = '0;
      nxt_rx_abort    = rx_in_frame_ff | (state_ff == TX_RD);
      nxt_rx_in_frame = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff       <= TX_IDLE;
      path_ff        <= PATH_SIDEBAND;
      prst_ff        <= 1'b0;
      ser_ff         <= '0;
      rx_ff          <= '0;
      rx_in_frame_ff <= 1'b0;
      tx_abort_ff    <= 1'b0;
      rx_abort_ff    <= 1'b0;
      pend_ff        <= 1'b0;
      sent_ff        <= 1'b0;
      msg_ff         <= 8'h00;
      acked_ff       <= 1'b0;
      poll_last_ff   <= 1'b0;
    end else begin
      state_ff       <= nxt_state;
      path_ff        <= nxt_path;
      prst_ff        <= nxt_prst;
      ser_ff         <= nxt_ser;
      rx_ff          <= nxt_rx;
      rx_in_frame_ff <= nxt_rx_in_frame;
      tx_abort_ff    <= nxt_tx_abort;
      rx_abort_ff    <= nxt_rx_abort;
      pend_ff        <= nxt_pend;
      sent_ff        <= nxt_sent;
      msg_ff         <= nxt_msg;
      acked_ff       <= nxt_acked;
      poll_last_ff   <= nxt_poll_last;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign o_platform_reset_n = prst_ff;
  assign o_serial_enable    = prst_ff;
  // reference clock runs while asked for or while link is up
  assign o_refclk_en        = ~req_sync_ff[1] | prst_ff;
  assign o_serial_tx        = ser_ff;
  assign o_rx               = rx_ff;
  assign o_tx_abort         = tx_abort_ff;
  assign o_rx_abort         = rx_abort_ff;
  assign o_msg_ready        = ~pend_ff;
  assign o_msg_acked        = acked_ff;
endmodule : phy_host_link_selector

// ### phy_link_defines.svh
// Purpose: constants for the host end of the PHY in-band link selector
// Assumes: 250 MHz system clock, single-byte sideband transactions
// Notes:   every offset, timing count and rate lives here as a macro
`ifndef PHY_LINK_DEFINES_SVH
`define PHY_LINK_DEFINES_SVH

// ****************************************************************
// clock and link rates
// ****************************************************************
`define CLK_PERIOD_NS     4
`define SERIAL_RATE_MBPS  1250
`define REFCLK_MHZ        100

// ****************************************************************
// sideband bit timing, half periods
// ****************************************************************
`define SB_HALF_100K_NS   5000
`define SB_HALF_400K_NS   1250
`define SB_HALF_1000K_NS  500
`define SB_HALF_100K_CYC  ((`SB_HALF_100K_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SB_HALF_400K_CYC  ((`SB_HALF_400K_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SB_HALF_1000K_CYC ((`SB_HALF_1000K_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SB_CNT_W          12
`define SB_ACK_BIT        4'h8

`endif

// ### phy_link_pkg.sv
// Purpose: shared types of the host link selector
// Assumes: phy_link_defines.svh on the include path
// Notes:   beats carry one byte each
package phy_link_pkg;
`include "phy_link_defines.svh"

  // one byte of a frame or in-band message
  typedef struct packed {
    logic [7:0] data;
    logic       last;
    logic       msg;
    logic       valid;
  } beat_t;

  typedef enum logic [1:0] {SB_100K, SB_400K, SB_1000K} sb_speed_t;
  typedef enum logic {PATH_SIDEBAND, PATH_SERIAL} path_t;
  typedef enum logic [2:0] {
    SB_IDLE, SB_START, SB_LOW, SB_HIGH, SB_STOP
  } sb_state_t;
  typedef enum logic [2:0] {
    TX_IDLE, TX_FRAME, TX_DROP, TX_MSG_SB, TX_RD
  } tx_state_t;

  // half bit period in clock cycles for a sideband speed
  function automatic logic [`SB_CNT_W-1:0] sb_half_cycles(sb_speed_t s);
    unique case (s)
      SB_100K:  return `SB_CNT_W'(`SB_HALF_100K_CYC);
      SB_400K:  return `SB_CNT_W'(`SB_HALF_400K_CYC);
      SB_1000K: return `SB_CNT_W'(`SB_HALF_1000K_CYC);
      default:  return `SB_CNT_W'(`SB_HALF_100K_CYC);
    endcase
  endfunction : sb_half_cycles
endpackage : phy_link_pkg

// ### sideband_shifter.sv
// Purpose: one-byte open-drain sideband transaction engine
// Assumes: host owns the clock line; device may stretch it
// Notes:   start, 8 data bits, ack slot, stop per transaction
`timescale 1ns/100ps
module sideband_shifter
  import phy_link_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_b,
  input  wire logic                 i_start,
  input  wire logic                 i_abort,
  input  wire logic                 i_read,
  input  wire logic [7:0]           i_byte,
  input  wire logic [`SB_CNT_W-1:0] i_half,
  input  wire logic                 i_sda_in,
  input  wire logic                 i_scl_in,
  output logic                      o_sda_out,
  output logic                      o_sda_oe,
  output logic                      o_scl_out,
  output logic                      o_scl_oe,
  output logic                      o_busy,
  output logic                      o_done,
  output logic                      o_ack,
  output logic [7:0]                o_rd_byte
);
  sb_state_t              state_ff, nxt_state;
  logic [`SB_CNT_W-1:0]   cnt_ff, nxt_cnt, half_ff, nxt_half;
  logic [3:0]             bit_ff, nxt_bit;
  logic [7:0]             shreg_ff, nxt_shreg;
  logic                   read_ff, nxt_read, ack_ff, nxt_ack;
  logic                   scl_oe_ff, nxt_scl_oe, sda_oe_ff, nxt_sda_oe;
  logic                   done_ff, nxt_done;
  logic [1:0]             sda_sync_ff, scl_sync_ff;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sda_sync_ff <= 2'h3;
      scl_sync_ff <= 2'h3;
    end else begin
      sda_sync_ff <= {sda_sync_ff[0], i_sda_in};
      scl_sync_ff <= {scl_sync_ff[0], i_scl_in};
    end
  end

  // ****************************************************************
  // bit sequencer
  // ****************************************************************
  // data bits are changed only while the clock is held low; start and stop move data with it high
  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_half   = half_ff;
    nxt_bit    = bit_ff;
    nxt_shreg  = shreg_ff;
    nxt_read   = read_ff;
    nxt_ack    = ack_ff;
    nxt_scl_oe = scl_oe_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_done   = 1'b0;
    unique case (state_ff)
      SB_IDLE: begin
        if (i_start) begin
          nxt_shreg  = i_byte;
          nxt_read   = i_read;
          nxt_half   = i_half;
          nxt_cnt    = i_half;
          nxt_sda_oe = 1'b1;                // start condition
          nxt_state  = SB_START;
        end
      end
      SB_START: begin
        if (cnt_ff == '0) begin
          nxt_scl_oe = 1'b1;
          nxt_bit    = 4'h0;
          nxt_cnt    = half_ff;
          nxt_state  = SB_LOW;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      SB_LOW: begin
        nxt_sda_oe = (bit_ff != `SB_ACK_BIT) & ~read_ff & ~shreg_ff[7];
        if (cnt_ff == '0) begin
          nxt_scl_oe = 1'b0;
          nxt_cnt    = half_ff;
          nxt_state  = SB_HIGH;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      SB_HIGH: begin
        // a held-low clock line is the device stretching
        if (!scl_sync_ff[1]) begin
          nxt_cnt = cnt_ff;
        end else if (cnt_ff == '0) begin
          nxt_scl_oe = 1'b1;
          nxt_cnt    = half_ff;
          if (bit_ff == `SB_ACK_BIT) begin
            nxt_ack    = ~sda_sync_ff[1];
            nxt_state  = SB_STOP;
          end else begin
            nxt_shreg  = {shreg_ff[6:0], sda_sync_ff[1]};
            nxt_bit    = bit_ff + 4'h1;
            nxt_state  = SB_LOW;
          end
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      SB_STOP: begin
        if (cnt_ff != '0) begin
          nxt_sda_oe = 1'b1;
          nxt_cnt = cnt_ff - 1'b1;
        end else if (scl_oe_ff) begin
          nxt_scl_oe = 1'b0;
          nxt_cnt    = half_ff;
        end else begin
          nxt_sda_oe = 1'b0;                 // stop condition
          nxt_done   = 1'b1;
          nxt_state  = SB_IDLE;
        end
      end
      default: nxt_state = SB_IDLE;
    endcase
    // a switch frees both lines
    if (i_abort) begin
      nxt_state  = SB_IDLE;
      nxt_scl_oe = 1'b0;
      nxt_sda_oe = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff  <= SB_IDLE;
      cnt_ff    <= '0;
      half_ff   <= '0;
      bit_ff    <= 4'h0;
      shreg_ff  <= 8'h00;
      read_ff   <= 1'b0;
      ack_ff    <= 1'b0;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      done_ff   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      half_ff   <= nxt_half;
      bit_ff    <= nxt_bit;
      shreg_ff  <= nxt_shreg;
      read_ff   <= nxt_read;
      ack_ff    <= nxt_ack;
      scl_oe_ff <= nxt_scl_oe;
      sda_oe_ff <= nxt_sda_oe;
      done_ff   <= nxt_done;
    end
  end

  assign o_sda_out = 1'b0;                   // open drain: low or off
  assign o_scl_out = 1'b0;
  assign o_sda_oe  = sda_oe_ff;
  assign o_scl_oe  = scl_oe_ff;
  assign o_busy    = (state_ff != SB_IDLE);
  assign o_done    = done_ff;
  assign o_ack     = ack_ff;
  assign o_rd_byte = shreg_ff;
endmodule : sideband_shifter

// ### phy_link_sva.sv
// Purpose: port assertions for the host link selector
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound onto the top module from tb
`timescale 1ns/100ps
module phy_link_sva
  import phy_link_pkg::*;
(
  input  wire logic  i_clk,
  input  wire logic  i_rst_b,
  input  wire logic  i_sys_active,
  input  wire logic  o_platform_reset_n,
  input  wire logic  o_serial_enable,
  input  wire logic  o_tx_abort,
  input  wire beat_t o_serial_tx,
  input  wire logic  i_serial_ready,
  input  wire beat_t i_serial_rx,
  input  wire beat_t o_rx,
  input  wire logic  o_msg_ready,
  input  wire logic  o_msg_acked,
  input  wire logic  o_sideband_data_pin_oe,
  input  wire logic  o_sideband_clock_pin_oe,
  input  wire logic  i_refclk_req_n,
  input  wire logic  o_refclk_en
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  // ****************************************************************
  // sequences
  // ****************************************************************
  sequence s_switch;
    i_sys_active != o_platform_reset_n;
  endsequence
  // a few cycles of grace for the shifter to let go of the lines
  sequence s_serial_settled;
    o_serial_enable [*4];
  endsequence
  sequence s_req_held;
    !i_refclk_req_n [*4];
  endsequence

  // ****************************************************************
  // properties
  // ****************************************************************
  path_follow_a: assert property (
    s_switch |=> o_platform_reset_n == $past(i_sys_active))
    else $error("path did not follow the power request");
  serial_en_a: assert property (
    o_serial_enable == $past(i_sys_active))
    else $error("serial enable did not follow request");
  sb_quiet_a: assert property (
    s_serial_settled |-> !o_sideband_data_pin_oe && !o_sideband_clock_pin_oe)
    else $error("sideband driven while on serial path");
  serial_idle_a: assert property (
    !o_serial_enable |-> !o_serial_tx.valid)
    else $error("serial beat offered while on sideband");
  abort_cause_a: assert property (
    o_tx_abort |-> $changed(o_platform_reset_n))
    else $error("transmit abort without a path switch");
  tx_hold_a: assert property (
    o_serial_tx.valid && !i_serial_ready && i_sys_active && o_serial_enable
    |=> $stable(o_serial_tx))
    else $error("stalled serial beat changed");
  rx_fwd_a: assert property (
    i_serial_rx.valid && o_serial_enable && i_sys_active
    |=> o_rx == $past(i_serial_rx))
    else $error("serial receive beat not forwarded");
  acked_pulse_a: assert property (
    o_msg_acked |-> o_msg_ready && !$past(o_msg_ready))
    else $error("acknowledge without a pending message");
  refclk_req_a: assert property (
    s_req_held |-> o_refclk_en)
    else $error("clock request not honoured");
endmodule : phy_link_sva

// ### phy_device_model.sv
// Purpose: behavioural PHY facing the host link selector
// Assumes: sideband lines pulled up, no clock stretching
// Notes:   serial and sideband bytes land in one queue
`timescale 1ns/100ps
module phy_device_model
  import phy_link_pkg::*;
#(
  parameter logic [7:0] RD_BYTE = 8'h5A
)
(
  input  wire logic  i_clk,
  input  wire logic  i_serial_enable,
  input  wire beat_t i_serial_tx,
  input  wire logic  i_slow,
  input  wire logic  i_hold_ack,
  input  wire logic  i_sb_read,
  input  wire logic  i_want_clk,
  input  wire logic  i_sda,
  input  wire logic  i_scl,
  output logic       o_serial_ready = 1'h0,
  output logic       o_serial_msg_ack,
  output logic       o_sda_oe = 1'h0,
  output logic       o_refclk_req_n
);
  logic [9:0] got [$];
  logic [1:0] ack_dly = 2'h0;
  logic [7:0] sh = 8'h00;
  int         cnt = 9;

  // ****************************************************************
  // serial link side
  // ****************************************************************
  // slow mode drops ready every other cycle so the host must hold
  always @(posedge i_clk) begin
    o_serial_ready <= i_serial_enable && !(i_slow && o_serial_ready);
    ack_dly <= {ack_dly[0], o_serial_ready & i_serial_tx.valid
                & i_serial_tx.msg & !i_hold_ack};
    if (o_serial_ready && i_serial_tx.valid)
      got.push_back({i_serial_tx.msg, i_serial_tx.last, i_serial_tx.data});
  end
  assign o_serial_msg_ack = ack_dly[1];
  assign o_refclk_req_n   = !i_want_clk;

  // ****************************************************************
  // sideband side
  // ****************************************************************
  // start: data falls while clock is high
  always @(negedge i_sda) if (i_scl) cnt = 0;
  // sample on the rising clock, keep a written byte
  always @(posedge i_scl) if (cnt < 9) begin
    if (cnt < 8) sh = {sh[6:0], i_sda};
    cnt++;
    if (cnt == 8 && !i_sb_read) got.push_back({2'h0, sh});
  end
  // read bits or the ack are set on the falling clock and held through the high half
  always @(negedge i_scl)
    o_sda_oe = (cnt < 8) ? (i_sb_read && !RD_BYTE[7 - cnt])
                         : (cnt == 8 && !i_sb_read);
  // a move to the serial link abandons a half-done byte
  always @(posedge i_serial_enable) begin
    o_sda_oe = 1'h0;
    cnt = 9;
  end
endmodule : phy_device_model

// ### tb.sv
// Purpose: self-checking bench for the host link selector
// Assumes: 250 MHz clock, device model on the far side
// Notes:   sideband runs mostly at the fastest rate to stay short
`timescale 1ns/100ps
`define CHK(name, exp, seen) begin \
  compares++; \
  if ((seen) !== (exp)) begin \
    n_mismatch++; \
    $display("mismatch %s exp %h got %h", name, exp, seen); \
  end \
end
module tb
  import phy_link_pkg::*;
;
  logic      i_clk = 1'h0, i_rst_b = 1'h0, i_sys_active = 1'h0;
  logic      i_rx_poll = 1'h0, i_rx_poll_last = 1'h0;
  logic      slow = 1'h0, hold_ack = 1'h0, sb_read = 1'h0, want_clk = 1'h0;
  sb_speed_t i_sb_speed;
  beat_t     i_tx, i_msg, i_serial_rx, o_rx, o_serial_tx;
  logic      o_tx_ready, o_tx_abort, o_msg_ready, o_msg_acked, o_rx_abort;
  logic      i_serial_ready, i_serial_msg_ack, o_serial_enable, dev_oe;
  logic      o_platform_reset_n, i_refclk_req_n, o_refclk_en;
  logic      o_sideband_data_pin_oe, o_sideband_clock_pin_oe;
  logic [9:0] v;
  int        n_mismatch = 0, compares = 0, n_abort = 0, k;
  // open-drain lines with pull-ups
  wire i_sideband_data_pin  = !(o_sideband_data_pin_oe | dev_oe);
  wire i_sideband_clock_pin = !o_sideband_clock_pin_oe;

  phy_host_link_selector u_phy_host_link_selector (
    .i_clk, .i_rst_b, .i_sys_active, .i_sb_speed, .i_tx, .o_tx_ready,
    .o_tx_abort, .i_msg, .o_msg_ready, .o_msg_acked, .o_rx, .o_rx_abort,
    .i_rx_poll, .i_rx_poll_last, .o_serial_tx, .i_serial_ready,
    .i_serial_rx, .i_serial_msg_ack, .o_serial_enable, .o_platform_reset_n,
    .i_refclk_req_n, .o_refclk_en, .i_sideband_data_pin,
    .o_sideband_data_pin(), .o_sideband_data_pin_oe, .i_sideband_clock_pin,
    .o_sideband_clock_pin(), .o_sideband_clock_pin_oe);
  phy_device_model u_dev (
    .i_clk, .i_serial_enable(o_serial_enable), .i_serial_tx(o_serial_tx),
    .i_slow(slow), .i_hold_ack(hold_ack), .i_sb_read(sb_read),
    .i_want_clk(want_clk), .i_sda(i_sideband_data_pin),
    .i_scl(i_sideband_clock_pin), .o_serial_ready(i_serial_ready),
    .o_serial_msg_ack(i_serial_msg_ack), .o_sda_oe(dev_oe),
    .o_refclk_req_n(i_refclk_req_n));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  initial forever #2 i_clk = ~i_clk;
  // abort pulses are one cycle long, so count them as they pass
  always @(posedge i_clk) n_abort += o_tx_abort + o_rx_abort;

  task automatic push(input bit m, input logic [7:0] d, input bit l);
    int j;
    @(negedge i_clk);
    if (m) i_msg = '{d, 1'h1, 1'h1, 1'h1};
    else i_tx = '{d, l, 1'h0, 1'h1};
    for (j = 0; j < 9000; j++) begin
      @(posedge i_clk);
      if (m ? o_msg_ready : o_tx_ready) break;
    end
    @(negedge i_clk);
    i_msg.valid = 1'h0;
    i_tx.valid = 1'h0;
  endtask : push
  task automatic wait_ack();
    int j;
    for (j = 0; j < 40000 && o_msg_acked !== 1'h1; j++) @(negedge i_clk);
    `CHK("msg_acked", 1'h1, o_msg_acked)
  endtask : wait_ack
  task automatic wait_q(input int n);
    int j;
    for (j = 0; j < 9000 && u_dev.got.size() < n; j++) @(negedge i_clk);
  endtask : wait_q
  task results();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_boot();
    `CHK("prst", 1'h0, o_platform_reset_n)
    `CHK("serial_en", 1'h0, o_serial_enable)
    want_clk = 1'h1;
    repeat (6) @(negedge i_clk);
    `CHK("refclk_en", 1'h1, o_refclk_en)
  endtask : t_boot
  // one message per sideband rate, slowest first
  task t_sb_msgs();
    for (k = 0; k < 3; k++) begin
      i_sb_speed = sb_speed_t'(k);
      push(1'h1, 8'hA0 + 8'(k), 1'h1);
      wait_ack();
      wait_q(1);
      v = u_dev.got.pop_front();
      `CHK("sb_byte", 8'hA0 + 8'(k), v[7:0])
    end
  endtask : t_sb_msgs
  task t_sb_read();
    sb_read = 1'h1;
    @(negedge i_clk);
    i_rx_poll = 1'h1;
    i_rx_poll_last = 1'h1;
    @(negedge i_clk);
    i_rx_poll = 1'h0;
    for (k = 0; k < 9000 && o_rx.valid !== 1'h1; k++) @(negedge i_clk);
    `CHK("sb_read", {8'h5A, 1'h1}, {o_rx.data, o_rx.last})
    sb_read = 1'h0;
  endtask : t_sb_read
  // switch up while the sideband byte is only a few bits in
  task t_up_resend();
    push(1'h1, 8'hC3, 1'h1);
    repeat (500) @(negedge i_clk);
    i_sys_active = 1'h1;
    repeat (2) @(negedge i_clk);
    `CHK("serial_en", 1'h1, o_serial_enable)
    wait_ack();
    wait_q(1);
    v = u_dev.got.pop_front();
    `CHK("resent", 10'h3C3, v)
  endtask : t_up_resend
  task t_serial();
    slow = 1'h1;
    for (k = 0; k < 3; k++) push(1'h0, 8'h10 + 8'(k), k == 2);
    wait_q(3);
    for (k = 0; k < 3; k++) begin
      v = u_dev.got.pop_front();
      `CHK("serial_tx", {1'h0, 1'(k == 2), 8'h10 + 8'(k)}, v)
    end
    slow = 1'h0;
    @(negedge i_clk);
    i_serial_rx = '{8'h6B, 1'h1, 1'h0, 1'h1};
    @(negedge i_clk);
    i_serial_rx = '{8'h94, 1'h0, 1'h0, 1'h1};
    `CHK("rx", {8'h6B, 1'h1, 1'h0, 1'h1}, o_rx)
  endtask : t_serial
  // unacked message and an open frame caught by a switch down
  task t_down_resend();
    hold_ack = 1'h1;
    push(1'h1, 8'h7E, 1'h1);
    wait_q(1);
    push(1'h0, 8'h21, 1'h0);
    wait_q(2);
    n_abort = 0;
    i_sys_active = 1'h0;
    repeat (2) @(negedge i_clk);
    `CHK("prst", 1'h0, o_platform_reset_n)
    `CHK("abort", 2, n_abort)
    push(1'h0, 8'h22, 1'h1);
    wait_ack();
    repeat (3000) @(negedge i_clk);
    `CHK("q_len", 3, u_dev.got.size())
    `CHK("sb_resend", 10'h07E, u_dev.got[2])
  endtask : t_down_resend

  // main sequence
  initial begin
    i_tx = '0;
    i_msg = '0;
    i_serial_rx = '0;
    i_sb_speed = SB_1000K;
    repeat (4) @(negedge i_clk);
    i_rst_b = 1'h1;
    t_boot();
    t_sb_msgs();
    t_sb_read();
    t_up_resend();
    t_serial();
    t_down_resend();
    results();
  end
  // watchdog, twice the expected run
  initial begin
    #400000;
    n_mismatch++;
    results();
  end
endmodule : tb
bind phy_host_link_selector phy_link_sva u_phy_link_sva (
  .i_clk, .i_rst_b, .i_sys_active, .o_platform_reset_n, .o_serial_enable,
  .o_tx_abort, .o_serial_tx, .i_serial_ready, .i_serial_rx, .o_rx,
  .o_msg_ready, .o_msg_acked, .o_sideband_data_pin_oe,
  .o_sideband_clock_pin_oe, .i_refclk_req_n, .o_refclk_en);
